// [src/sopad_decode.sv]
// Single-operand instruction decoder: splits the word, resolves the register against the
// active set and forms the operand address. Assumes fetch and memory logic on core_clk
// that answers each read with one mem_rd_valid pulse.
`timescale 1ns/100ps
`include "sopad_defs.svh"

module sopad_decode #(
    parameter int W = 16
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          instr_valid,
    input  wire logic [15:0]   instr_word,
    input  wire logic          byte_op,
    input  wire logic [15:0]   processor_status_word,
    input  wire logic          bank_sel,
    output logic               busy,
    output logic               decode_done,
    output logic      [9:0]    opcode,
    output logic               operand_is_reg,
    output logic      [2:0]    operand_reg,
    output logic      [W-1:0]  operand_value,
    output logic      [W-1:0]  operand_addr,
    output logic               mem_rd_req,
    output logic      [W-1:0]  mem_rd_addr,
    input  wire logic          mem_rd_valid,
    input  wire logic [W-1:0]  mem_rd_data,
    input  wire logic          ext_wr_en,
    input  wire logic [2:0]    ext_wr_idx,
    input  wire logic [W-1:0]  ext_wr_data,
    output logic               ext_wr_ready,
    output logic      [W-1:0]  hardware_stack_pointer,
    output logic      [W-1:0]  program_counter_register
);

    sopad_pkg::sopad_state_e state;
    sopad_pkg::sopad_state_e next_state;
    logic [2:0]   mode;
    logic [2:0]   next_mode;
    logic [2:0]   sel_reg;
    logic [2:0]   next_sel_reg;
    logic         next_decode_done;
    logic [9:0]   next_opcode;
    logic         next_operand_is_reg;
    logic [W-1:0] next_operand_value;
    logic [W-1:0] next_operand_addr;
    logic         next_mem_rd_req;
    logic [W-1:0] next_mem_rd_addr;

    logic [2:0]   new_mode;
    logic [2:0]   new_reg;
    logic [2:0]   rd_idx;
    logic [W-1:0] rd_data;
    logic [W-1:0] step;
    logic         dec_wr_en;
    logic [2:0]   dec_wr_idx;
    logic [W-1:0] dec_wr_data;
    logic         wr_en;
    logic [2:0]   wr_idx;
    logic [W-1:0] wr_data;

    // Field split of the incoming word.
    assign new_mode = {instr_word[`SOPAD_MODE_MSB:`SOPAD_MODE_LSB],
                       instr_word[`SOPAD_DEFER_BIT]};
    assign new_reg  = instr_word[`SOPAD_REG_MSB:`SOPAD_REG_LSB];

    // In idle the register is read straight from the word, later from the latched field.
    assign rd_idx = (state == sopad_pkg::SOPAD_ST_IDLE) ? new_reg : sel_reg;
    assign busy   = (state != sopad_pkg::SOPAD_ST_IDLE);

    // Deferred forms step by a whole word because the register then holds an address
    // of an address; stack and counter never go odd.
    always_comb begin
        if (new_mode[0] || new_reg == `SOPAD_REG_SP || new_reg == `SOPAD_REG_PC || !byte_op) begin
            step = `SOPAD_STEP_WORD;
        end else begin
            step = `SOPAD_STEP_BYTE;
        end
    end

    // Decoder pointer updates win the write port; outside logic waits on ext_wr_ready.
    assign wr_en        = dec_wr_en | ext_wr_en;
    assign wr_idx       = dec_wr_en ? dec_wr_idx : ext_wr_idx;
    assign wr_data      = dec_wr_en ? dec_wr_data : ext_wr_data;
    assign ext_wr_ready = ~dec_wr_en;

    sopad_regfile #(
        .W (W)
    ) u_regs (
        .core_clk                (core_clk),
        .rst_n                   (rst_n),
        .bank_sel                (bank_sel),
        .cur_mode                (processor_status_word[`SOPAD_PSW_CM_MSB:`SOPAD_PSW_CM_LSB]),
        .rd_idx                  (rd_idx),
        .rd_data                 (rd_data),
        .wr_en                   (wr_en),
        .wr_idx                  (wr_idx),
        .wr_data                 (wr_data),
        .hardware_stack_pointer  (hardware_stack_pointer),
        .program_counter_register(program_counter_register)
    );

    // Address formation sequence.
    always_comb begin
        next_state          = state;
        next_mode           = mode;
        next_sel_reg        = sel_reg;
        next_decode_done    = 1'b0;
        next_opcode         = opcode;
        next_operand_is_reg = operand_is_reg;
        next_operand_value  = operand_value;
        next_operand_addr   = operand_addr;
        next_mem_rd_req     = mem_rd_req;
        next_mem_rd_addr    = mem_rd_addr;
        dec_wr_en           = 1'b0;
        dec_wr_idx          = rd_idx;
        dec_wr_data         = rd_data;
        unique case (state)
            sopad_pkg::SOPAD_ST_IDLE: begin
                if (instr_valid) begin
                    next_opcode         = instr_word[`SOPAD_OPC_MSB:`SOPAD_OPC_LSB];
                    next_mode           = new_mode;
                    next_sel_reg        = new_reg;
                    next_operand_is_reg = 1'b0;
                    unique case (new_mode)
                        `SOPAD_MODE_REG: begin
                            next_operand_is_reg = 1'b1;
                            next_operand_value  = rd_data;
                            next_decode_done    = 1'b1;
                        end
                        3'h1: begin
                            next_operand_addr = rd_data;
                            next_decode_done  = 1'b1;
                        end
                        `SOPAD_MODE_AINC, 3'h3: begin
                            dec_wr_en   = 1'b1;
                            dec_wr_data = rd_data + step;
                            if (new_mode[0]) begin
                                next_mem_rd_req  = 1'b1;
                                next_mem_rd_addr = rd_data;
                                next_state       = sopad_pkg::SOPAD_ST_DEFER;
                            end else begin
                                next_operand_addr = rd_data;
                                next_decode_done  = 1'b1;
                            end
                        end
                        `SOPAD_MODE_ADEC, 3'h5: begin
                            dec_wr_en   = 1'b1;
                            dec_wr_data = rd_data - step;
                            if (new_mode[0]) begin
                                next_mem_rd_req  = 1'b1;
                                next_mem_rd_addr = rd_data - step;
                                next_state       = sopad_pkg::SOPAD_ST_DEFER;
                            end else begin
                                next_operand_addr = rd_data - step;
                                next_decode_done  = 1'b1;
                            end
                        end
                        `SOPAD_MODE_INDEX, 3'h7: begin
                            // The index word sits right after the instruction, at the counter.
                            next_mem_rd_req  = 1'b1;
                            next_mem_rd_addr = program_counter_register;
                            next_state       = sopad_pkg::SOPAD_ST_INDEX;
                        end
                    endcase
                end
            end
            sopad_pkg::SOPAD_ST_INDEX: begin
                if (mem_rd_valid) begin
                    // Counter moves past the index word; a counter-based index sees the moved value.
                    dec_wr_en   = 1'b1;
                    dec_wr_idx  = `SOPAD_REG_PC;
                    dec_wr_data = program_counter_register + `SOPAD_STEP_WORD;
                    if (mode[0]) begin
                        next_mem_rd_addr = rd_data + mem_rd_data;
                        next_state       = sopad_pkg::SOPAD_ST_DEFER;
                    end else begin
                        next_mem_rd_req   = 1'b0;
                        next_operand_addr = rd_data + mem_rd_data;
                        next_decode_done  = 1'b1;
                        next_state        = sopad_pkg::SOPAD_ST_IDLE;
                    end
                    if (sel_reg == `SOPAD_REG_PC) begin
                        next_mem_rd_addr  = rd_data + `SOPAD_STEP_WORD + mem_rd_data;
                        next_operand_addr = mode[0] ? operand_addr
                                                    : rd_data + `SOPAD_STEP_WORD + mem_rd_data;
                    end
                end
            end
            sopad_pkg::SOPAD_ST_DEFER: begin
                if (mem_rd_valid) begin
                    next_mem_rd_req   = 1'b0;
                    next_operand_addr = mem_rd_data;
                    next_decode_done  = 1'b1;
                    next_state        = sopad_pkg::SOPAD_ST_IDLE;
                end
            end
            // The fourth state code is never entered; recover to idle if it is ever seen.
            default: begin
                next_mem_rd_req = 1'b0;
                next_state      = sopad_pkg::SOPAD_ST_IDLE;
            end
        endcase
    end

    // Registers of the sequence.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state          <= sopad_pkg::SOPAD_ST_IDLE;
            mode           <= 3'h0;
            sel_reg        <= 3'h0;
            decode_done    <= 1'b0;
            opcode         <= 10'h000;
            operand_is_reg <= 1'b0;
            operand_value  <= `SOPAD_REG_RST;
            operand_addr   <= `SOPAD_REG_RST;
            mem_rd_req     <= 1'b0;
            mem_rd_addr    <= `SOPAD_REG_RST;
        end else begin
            state          <= next_state;
            mode           <= next_mode;
            sel_reg        <= next_sel_reg;
            decode_done    <= next_decode_done;
            opcode         <= next_opcode;
            operand_is_reg <= next_operand_is_reg;
            operand_value  <= next_operand_value;
            operand_addr   <= next_operand_addr;
            mem_rd_req     <= next_mem_rd_req;
            mem_rd_addr    <= next_mem_rd_addr;
        end
    end

    assign operand_reg = sel_reg;

endmodule : sopad_decode

// [src/sopad_defs.svh]
// Constants of the single-operand address decoder: field positions, codes, steps, reset values.
// Assumes it is included by bare name from each design file that needs it.
`ifndef SOPAD_DEFS_SVH
`define SOPAD_DEFS_SVH

// Instruction word fields.
`define SOPAD_OPC_MSB      15
`define SOPAD_OPC_LSB      6
`define SOPAD_MODE_MSB     5
`define SOPAD_MODE_LSB     4
`define SOPAD_DEFER_BIT    3
`define SOPAD_REG_MSB      2
`define SOPAD_REG_LSB      0

// Current-mode field of the processor status word.
`define SOPAD_PSW_CM_MSB   15
`define SOPAD_PSW_CM_LSB   14
`define SOPAD_CM_KERNEL    2'h0
`define SOPAD_CM_SUPER     2'h1
`define SOPAD_CM_USER      2'h3

// Direct mode codes; the odd code above each is its deferred form.
`define SOPAD_MODE_REG     3'h0
`define SOPAD_MODE_AINC    3'h2
`define SOPAD_MODE_ADEC    3'h4
`define SOPAD_MODE_INDEX   3'h6

// Register numbers with a fixed role.
`define SOPAD_REG_SP       3'h6
`define SOPAD_REG_PC       3'h7

// Pointer steps.
`define SOPAD_STEP_BYTE    16'h0001
`define SOPAD_STEP_WORD    16'h0002

// Reset value of every register.
`define SOPAD_REG_RST      16'h0000

`endif

// [src/sopad_pkg.sv]
// Types shared by the single-operand address decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package sopad_pkg;

    typedef logic [15:0] sopad_word_t;
    typedef logic [2:0]  sopad_reg_t;

    typedef enum logic [1:0] {
        SOPAD_ST_IDLE,
        SOPAD_ST_INDEX,
        SOPAD_ST_DEFER
    } sopad_state_e;

endpackage : sopad_pkg

// [src/sopad_regfile.sv]
// Register file of the decoder: two banks of six general registers, three stack pointers
// and one shared program counter. Assumes a single write port arbitrated by its user.
`timescale 1ns/100ps
`include "sopad_defs.svh"

module sopad_regfile #(
    parameter int W = 16
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          bank_sel,
    input  wire logic [1:0]    cur_mode,
    input  wire logic [2:0]    rd_idx,
    output logic      [W-1:0]  rd_data,
    input  wire logic          wr_en,
    input  wire logic [2:0]    wr_idx,
    input  wire logic [W-1:0]  wr_data,
    output logic      [W-1:0]  hardware_stack_pointer,
    output logic      [W-1:0]  program_counter_register
);

    logic [W-1:0] general_register_bank [2][6];
    logic [W-1:0] next_general_register_bank [2][6];
    logic [W-1:0] stack_pointer_register [3];
    logic [W-1:0] next_stack_pointer_register [3];
    logic [W-1:0] next_program_counter_register;
    logic [1:0]   sp_sel;

    // The unused mode code 2 falls back on the kernel copy so a bad status word never
    // leaves the stack unselected.
    always_comb begin
        unique case (cur_mode)
            `SOPAD_CM_SUPER: sp_sel = 2'h1;
            `SOPAD_CM_USER:  sp_sel = 2'h2;
            default:         sp_sel = 2'h0;
        endcase
    end

    // Reads resolve against the active bank and mode copy only.
    always_comb begin
        hardware_stack_pointer = stack_pointer_register[sp_sel];
        if (rd_idx == `SOPAD_REG_PC) begin
            rd_data = program_counter_register;
        end else if (rd_idx == `SOPAD_REG_SP) begin
            rd_data = stack_pointer_register[sp_sel];
        end else begin
            rd_data = general_register_bank[bank_sel][rd_idx];
        end
    end

    // Next-state of the whole file; only the addressed copy changes.
    always_comb begin
        next_general_register_bank    = general_register_bank;
        next_stack_pointer_register   = stack_pointer_register;
        next_program_counter_register = program_counter_register;
        if (wr_en) begin
            if (wr_idx == `SOPAD_REG_PC) begin
                next_program_counter_register = wr_data;
            end else if (wr_idx == `SOPAD_REG_SP) begin
                next_stack_pointer_register[sp_sel] = wr_data;
            end else begin
                next_general_register_bank[bank_sel][wr_idx] = wr_data;
            end
        end
    end

    // Storage.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int b = 0; b < 2; b++) begin
                for (int r = 0; r < 6; r++) begin
                    general_register_bank[b][r] <= `SOPAD_REG_RST;
                end
            end
            for (int s = 0; s < 3; s++) begin
                stack_pointer_register[s] <= `SOPAD_REG_RST;
            end
            program_counter_register <= `SOPAD_REG_RST;
        end else begin
            general_register_bank    <= next_general_register_bank;
            stack_pointer_register   <= next_stack_pointer_register;
            program_counter_register <= next_program_counter_register;
        end
    end

endmodule : sopad_regfile

// [dv/sopad_decode_assertions.sv]
// Checker for the single-operand decoder, watching only the top module's ports.
// Assumes one clock domain and the bind in the bench top file.
`timescale 1ns/100ps

module sopad_decode_chk #(
    parameter int W = 16
) (
    input wire logic          core_clk,
    input wire logic          rst_n,
    input wire logic          instr_valid,
    input wire logic [15:0]   instr_word,
    input wire logic          busy,
    input wire logic          decode_done,
    input wire logic [9:0]    opcode,
    input wire logic          operand_is_reg,
    input wire logic [2:0]    operand_reg,
    input wire logic          mem_rd_req,
    input wire logic [W-1:0]  mem_rd_addr,
    input wire logic          mem_rd_valid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // A word is taken only while idle; mode codes split into quick and memory paths.
    sequence s_take;
        instr_valid && !busy;
    endsequence
    sequence s_take_direct;
        s_take ##0 (instr_word[5:3] inside {3'h0, 3'h1, 3'h2, 3'h4});
    endsequence
    sequence s_take_mem;
        s_take ##0 (instr_word[5:3] inside {3'h3, 3'h5, 3'h6, 3'h7});
    endsequence

    a_opcode_taken: assert property (s_take |=> opcode == $past(instr_word[15:6]))
        else $error("opcode differs from taken word");
    a_reg_taken: assert property (s_take |=> operand_reg == $past(instr_word[2:0]))
        else $error("register number differs from taken word");
    a_reg_flag: assert property (
            s_take |=> operand_is_reg == ($past(instr_word[5:3]) == 3'h0))
        else $error("register operand flag wrong");
    a_direct_quick: assert property (
            s_take_direct |=> decode_done && !busy && !mem_rd_req)
        else $error("direct mode not done in one cycle");
    a_memory_start: assert property (
            s_take_mem |=> mem_rd_req && busy && !decode_done)
        else $error("memory mode did not start a read");
    a_req_held: assert property (
            mem_rd_req && !mem_rd_valid |=> mem_rd_req && $stable(mem_rd_addr))
        else $error("read request dropped or moved before answer");
    a_done_ends_busy: assert property ($fell(busy) |-> decode_done)
        else $error("busy ended without done");
    a_idle_no_read: assert property (!busy |-> !mem_rd_req)
        else $error("read request while idle");
endmodule : sopad_decode_chk

// [dv/sopad_mem_model.sv]
// Behavioural operand memory: answers each read after a chosen delay with addr xor a key.
// Assumes requests are held until the answer pulse, as the decoder promises.
`timescale 1ns/100ps

module sopad_mem_model #(
    parameter logic [15:0] KEY = 16'h3c5a
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [1:0]   lat,
    input  wire logic         mem_rd_req,
    input  wire logic [15:0]  mem_rd_addr,
    output logic              mem_rd_valid,
    output logic [15:0]       mem_rd_data
);
    logic [2:0] cnt;

    // Data outside the answer pulse toggles every cycle so a sample one cycle late never matches.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_rd_valid <= 1'b0;
            mem_rd_data  <= 16'hffff;
            cnt          <= 3'h0;
        end else if (mem_rd_valid) begin
            mem_rd_valid <= 1'b0;
            mem_rd_data  <= ~mem_rd_data;
            cnt          <= 3'h0;
        end else if (mem_rd_req && cnt >= {1'b0, lat}) begin
            mem_rd_valid <= 1'b1;
            mem_rd_data  <= mem_rd_addr ^ KEY;
        end else begin
            mem_rd_data <= ~mem_rd_data;
            cnt         <= mem_rd_req ? cnt + 3'h1 : 3'h0;
        end
    end
endmodule : sopad_mem_model

// [dv/testbench.sv]
// Bench top: drives the decoder through instruction and register-write calls.
// Assumes the memory model on the read port and the checker bound below.
`timescale 1ns/100ps

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_fail++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module testbench;
    localparam logic [15:0] KEY = 16'h3c5a;
    logic core_clk = 0, rst_n = 0, instr_valid = 0, byte_op = 0, bank_sel = 0;
    logic [15:0] instr_word = '0, processor_status_word = '0, ext_wr_data = '0;
    logic ext_wr_en = 0;
    logic [2:0] ext_wr_idx = '0;
    logic [1:0] lat = '0;
    logic busy, decode_done, operand_is_reg, mem_rd_req, mem_rd_valid, ext_wr_ready;
    logic [9:0] opcode;
    logic [2:0] operand_reg;
    logic [15:0] operand_value, operand_addr, mem_rd_addr, mem_rd_data, sp_out, pc_out;
    logic [15:0] rv [0:7];
    logic [15:0] a, x, st;
    int n_fail = 0, samples_checked = 0;

    always #2.5 core_clk = ~core_clk;

    sopad_decode #(.W(16)) DUT (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .byte_op(byte_op), .processor_status_word(processor_status_word),
        .bank_sel(bank_sel), .busy(busy), .decode_done(decode_done), .opcode(opcode),
        .operand_is_reg(operand_is_reg), .operand_reg(operand_reg),
        .operand_value(operand_value), .operand_addr(operand_addr), .mem_rd_req(mem_rd_req),
        .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
        .ext_wr_en(ext_wr_en), .ext_wr_idx(ext_wr_idx), .ext_wr_data(ext_wr_data),
        .ext_wr_ready(ext_wr_ready), .hardware_stack_pointer(sp_out),
        .program_counter_register(pc_out));

    sopad_mem_model #(.KEY(KEY)) u_mem (.core_clk(core_clk), .rst_n(rst_n), .lat(lat),
        .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid),
        .mem_rd_data(mem_rd_data));

    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // Register write; the decoder is idle here, so the write is never dropped. The spare
    // edge after the strobe falls keeps two writes in a row from sharing one time step.
    task automatic wr(input logic [2:0] idx, input logic [15:0] d);
        ext_wr_en = 1; ext_wr_idx = idx; ext_wr_data = d;
        `CHK("ext_wr_ready", 1'b1, ext_wr_ready)
        @(posedge core_clk); #1;
        ext_wr_en = 0;
        @(posedge core_clk); #1;
    endtask : wr

    // One instruction: present for the take edge, then wait for done under a bound.
    task automatic issue(input logic [2:0] md, input logic [2:0] rg, input logic bt);
        int i;
        logic [9:0] op;
        op = {bt, 2'h1, md, rg, 1'b1};
        // An idle edge first, so instr_valid never falls and rises in one time step.
        @(posedge core_clk); #1;
        instr_word = {op, md, rg}; byte_op = bt; instr_valid = 1;
        @(posedge core_clk); #1;
        instr_valid = 0;
        i = 0;
        while (decode_done !== 1'b1 && i < 60) begin
            @(posedge core_clk); #1; i++;
        end
        if (decode_done !== 1'b1) begin
            n_fail++; $display("[ERR] decode_done expected 1 seen timeout"); conclude();
        end
        `CHK("opcode", op, opcode)
        `CHK("operand_reg", rg, operand_reg)
    endtask : issue

    initial begin
        repeat (4) @(posedge core_clk);
        #1 rst_n = 1;
        `CHK("busy", 1'b0, busy)
        `CHK("pc", 16'h0000, pc_out)
        // Two banks hold distinct contents for the same register numbers.
        for (int b = 0; b < 2; b++) begin
            bank_sel = b[0];
            for (int n = 0; n < 6; n++) begin
                wr(n[2:0], 16'h1000 + 16'(b * 16 + n));
            end
        end
        for (int b = 0; b < 2; b++) begin
            bank_sel = b[0];
            for (int n = 0; n < 6; n++) begin
                issue(3'h0, n[2:0], 1'b0);
                `CHK("bank reg", 16'h1000 + 16'(b * 16 + n), operand_value)
                `CHK("is_reg", 1'b1, operand_is_reg)
            end
        end
        // Stack copies per current mode; code 10 falls back to the kernel copy.
        for (int m = 0; m < 4; m++) begin
            processor_status_word = {m[1:0], 14'h0};
            if (m != 2) wr(3'h6, 16'h2000 + 16'(m));
        end
        wr(3'h7, 16'h0400);
        // Each new status word is given a whole cycle so drives stay one step after the edge.
        for (int m = 0; m < 4; m++) begin
            processor_status_word = {m[1:0], 14'h0}; bank_sel = m[0];
            @(posedge core_clk); #1;
            `CHK("stack copy", 16'h2000 + 16'(m == 2 ? 0 : m), sp_out)
            `CHK("shared pc", 16'h0400, pc_out)
        end
        processor_status_word = '0; bank_sel = 0;
        for (int n = 0; n < 6; n++) rv[n] = 16'h1000 + 16'(n);
        rv[6] = 16'h2000; rv[7] = 16'h0400;
        // Every mode on plain, stack and counter registers, word and byte, varied latency.
        for (int md = 0; md < 8; md++) begin
            for (int k = 0; k < 8; k++) begin
                logic [2:0] rg;
                logic bt;
                rg = (k[2:1] == 2'h0) ? 3'h0 : (k[2:1] == 2'h1) ? 3'h5 : {2'h3, k[1]};
                bt = k[0];
                lat = k[1:0];
                st = (rg >= 3'h6 || !bt) ? 16'h0002 : 16'h0001;
                case (md)
                    0: a = rv[rg];
                    1: a = rv[rg];
                    2: begin a = rv[rg]; rv[rg] += st; end
                    3: begin a = rv[rg] ^ KEY; rv[rg] += 16'h0002; end
                    4: begin rv[rg] -= st; a = rv[rg]; end
                    5: begin rv[rg] -= 16'h0002; a = rv[rg] ^ KEY; end
                    default: begin
                        x = rv[7] ^ KEY; rv[7] += 16'h0002; a = rv[rg] + x;
                        if (md == 7) a = a ^ KEY;
                    end
                endcase
                issue(md[2:0], rg, bt);
                if (md == 0) `CHK("value", a, operand_value)
                else `CHK("addr", a, operand_addr)
                `CHK("pc after", rv[7], pc_out)
                `CHK("sp after", rv[6], sp_out)
                issue(3'h0, rg, 1'b0);
                `CHK("reg after", rv[rg], operand_value)
            end
        end
        conclude();
    end
endmodule : testbench

bind sopad_decode sopad_decode_chk #(.W(W)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_word(instr_word), .busy(busy),
    .decode_done(decode_done), .opcode(opcode), .operand_is_reg(operand_is_reg),
    .operand_reg(operand_reg), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_valid(mem_rd_valid));
